// ==== pkg/pha_params.svh ====
// offsets, field positions, reset values and timing for the palette port
`ifndef PHA_PARAMS_SVH
`define PHA_PARAMS_SVH

`define PHA_SEL_ADDR_WR 4'h0
`define PHA_SEL_PAL_DATA 4'h1
`define PHA_SEL_PIX_MASK 4'h2
`define PHA_SEL_ADDR_RD 4'h3
`define PHA_SEL_CC_ADDR_WR 4'h4
`define PHA_SEL_CC_DATA 4'h5
`define PHA_SEL_CTRL_A 4'h6
`define PHA_SEL_CC_ADDR_RD 4'h7
`define PHA_SEL_CTRL_B 4'h8
`define PHA_SEL_CTRL_C 4'h9
`define PHA_SEL_STATUS 4'ha
`define PHA_SEL_CBM_DATA 4'hb
`define PHA_SEL_CUR_X_LO 4'hc
`define PHA_SEL_CUR_X_HI 4'hd
`define PHA_SEL_CUR_Y_LO 4'he
`define PHA_SEL_CUR_Y_HI 4'hf

`define PHA_CTRL_A_WIDTH_BIT 1
`define PHA_STATUS_BUSY_BIT 2
`define PHA_PHASE_RED 2'h0
`define PHA_PHASE_BLUE 2'h2
`define PHA_SIX_BIT_MASK 8'h3f
`define PHA_MASK_RST 8'hff
`define PHA_CTRL_RST 8'h00
`define PHA_PAL_DEPTH 256
`define PHA_CC_DEPTH 4
`define PHA_CBM_DEPTH 1024
`define PHA_STROBE_GAP_CYCLES 2

`endif

// ==== pkg/pha_pkg.sv ====
// types for the palette host access port
package pha_pkg;

    typedef enum logic [4:0] {
        MODE_IDLE  = 5'b00001,
        MODE_PAL_WR = 5'b00010,
        MODE_PAL_RD = 5'b00100,
        MODE_CC_WR = 5'b01000,
        MODE_CC_RD = 5'b10000
    } pha_mode_t;

    typedef enum logic [4:0] {
        PEND_NONE = 5'b00001,
        PEND_STORE_PAL = 5'b00010,
        PEND_FETCH_PAL = 5'b00100,
        PEND_STORE_CC = 5'b01000,
        PEND_FETCH_CC = 5'b10000
    } pha_pend_t;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic [3:0] reg_select;
        logic [7:0] host_data_bus;
    } pha_host_t;

    typedef struct packed {
        logic [7:0] horiz;
        logic [7:0] horiz_hi;
        logic [7:0] vert;
        logic [7:0] vert_hi;
    } pha_cursor_pos_t;

    typedef struct packed {
        pha_mode_t mode;
        pha_pend_t pend;
        logic [7:0] addr;
        logic [1:0] cursor_addr_ext;
        logic [1:0] color_phase;
        logic [2:0][7:0] hold;
        logic [7:0] pix_mask;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_c;
        pha_cursor_pos_t cur_pos;
        logic wr_n_q;
        logic rd_n_q;
        logic [3:0] sel_q;
        logic [7:0] wdata_q;
        logic [7:0] rdata;
        logic data_oe;
        logic [23:0] color_out;
    } pha_state_t;

endpackage : pha_pkg

// ==== verilog/pha_palette_port.sv ====
// palette host access port: register select decode, palette and cursor
// colour sequencing, cursor bitmap access and pixel lookup output
`timescale 1ns/1ps
`include "pha_params.svh"

module pha_palette_port
    import pha_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire pha_host_t host_i,
    input wire logic [1:0] cursor_addr_ext_i,
    input wire logic large_cursor_i,
    input wire logic [7:0] pixel_index_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic [23:0] color_out_o,
    output logic [7:0] pixel_and_mask_o,
    output logic [7:0] control_reg_a_o,
    output logic [7:0] control_reg_b_o,
    output logic [7:0] control_reg_c_o,
    output pha_cursor_pos_t cursor_pos_o
);

    pha_state_t st_ff;
    pha_state_t nxt_st;

    logic [23:0] pal_mem [`PHA_PAL_DEPTH];
    logic [23:0] cc_mem [`PHA_CC_DEPTH];
    logic [7:0] cbm_mem [`PHA_CBM_DEPTH];

    logic pal_we;
    logic cc_we;
    logic cbm_we;
    logic [7:0] cbm_wdata;
    logic [9:0] cbm_idx;
    logic [9:0] cbm_idx_inc;
    logic wr_rise;
    logic rd_fall;
    logic rd_rise;
    logic gap;
    logic do_op;
    logic eight_bit;
    logic [7:0] wcolor;
    logic [7:0] rcolor;
    logic [23:0] hold_word;
    logic [7:0] pix_addr;
    logic [7:0] status;

    // phase advance modulo three
    function automatic logic [1:0] phase_next(input logic [1:0] p);
        phase_next = (p == `PHA_PHASE_BLUE) ? `PHA_PHASE_RED : p + 2'h1;
    endfunction : phase_next

    always_comb begin
        nxt_st = st_ff;
        pal_we = 1'b0;
        cc_we = 1'b0;
        cbm_we = 1'b0;
        cbm_wdata = st_ff.wdata_q;
        wr_rise = !st_ff.wr_n_q && host_i.wr_n;
        rd_fall = st_ff.rd_n_q && !host_i.rd_n;
        rd_rise = !st_ff.rd_n_q && host_i.rd_n;
        gap = host_i.wr_n && host_i.rd_n && st_ff.wr_n_q && st_ff.rd_n_q;
        do_op = gap && (st_ff.pend != PEND_NONE);
        eight_bit = st_ff.ctrl_a[`PHA_CTRL_A_WIDTH_BIT];
        // 6-bit mode drops top bits both ways
        wcolor = eight_bit ? st_ff.wdata_q
                           : (st_ff.wdata_q & `PHA_SIX_BIT_MASK);
        rcolor = eight_bit ? st_ff.hold[st_ff.color_phase]
                 : (st_ff.hold[st_ff.color_phase]
                    & `PHA_SIX_BIT_MASK);
        hold_word = {st_ff.hold[0], st_ff.hold[1], st_ff.hold[2]};
        // large cursor uses the two extension bits on top
        cbm_idx = large_cursor_i ? {st_ff.cursor_addr_ext, st_ff.addr}
                                 : {2'h0, st_ff.addr};
        cbm_idx_inc = cbm_idx + 10'h001;
        pix_addr = pixel_index_i & st_ff.pix_mask;
        status = 8'h00;
        status[`PHA_STATUS_BUSY_BIT] = (st_ff.pend != PEND_NONE);
        status[1:0] = st_ff.color_phase;

        nxt_st.wr_n_q = host_i.wr_n;
        nxt_st.rd_n_q = host_i.rd_n;
        if (!host_i.wr_n || !host_i.rd_n) begin
            nxt_st.sel_q = host_i.reg_select;
        end
        if (!host_i.wr_n) begin
            nxt_st.wdata_q = host_i.host_data_bus;
        end

        // read data, presented from the cycle after the falling strobe
        if (rd_fall) begin
            nxt_st.data_oe = 1'b1;
            case (host_i.reg_select)
                `PHA_SEL_ADDR_WR, `PHA_SEL_ADDR_RD,
                `PHA_SEL_CC_ADDR_WR, `PHA_SEL_CC_ADDR_RD: begin
                    nxt_st.rdata = st_ff.addr;
                end
                `PHA_SEL_PAL_DATA: begin
                    nxt_st.rdata = (st_ff.mode == MODE_PAL_RD)
                                   ? rcolor : 8'h00;
                end
                `PHA_SEL_CC_DATA: begin
                    nxt_st.rdata = (st_ff.mode == MODE_CC_RD)
                                   ? rcolor : 8'h00;
                end
                `PHA_SEL_PIX_MASK: begin
                    nxt_st.rdata = st_ff.pix_mask;
                end
                `PHA_SEL_CTRL_A: begin
                    nxt_st.rdata = st_ff.ctrl_a;
                end
                `PHA_SEL_CTRL_B: begin
                    nxt_st.rdata = st_ff.ctrl_b;
                end
                `PHA_SEL_CTRL_C: begin
                    nxt_st.rdata = st_ff.ctrl_c;
                end
                `PHA_SEL_STATUS: begin
                    nxt_st.rdata = status;
                end
                `PHA_SEL_CBM_DATA: begin
                    nxt_st.rdata = cbm_mem[cbm_idx];
                end
                `PHA_SEL_CUR_X_LO: begin
                    nxt_st.rdata = st_ff.cur_pos.horiz;
                end
                `PHA_SEL_CUR_X_HI: begin
                    nxt_st.rdata = st_ff.cur_pos.horiz_hi;
                end
                `PHA_SEL_CUR_Y_LO: begin
                    nxt_st.rdata = st_ff.cur_pos.vert;
                end
                default: begin
                    nxt_st.rdata = st_ff.cur_pos.vert_hi;
                end
            endcase
        end

        // read side effects at the end of the read strobe
        if (rd_rise) begin
            nxt_st.data_oe = 1'b0;
            case (st_ff.sel_q)
                `PHA_SEL_PAL_DATA: begin
                    if (st_ff.mode == MODE_PAL_RD) begin
                        nxt_st.color_phase =
                            phase_next(st_ff.color_phase);
                        if (st_ff.color_phase == `PHA_PHASE_BLUE) begin
                            nxt_st.pend = PEND_FETCH_PAL;
                        end
                    end
                end
                `PHA_SEL_CC_DATA: begin
                    if (st_ff.mode == MODE_CC_RD) begin
                        nxt_st.color_phase =
                            phase_next(st_ff.color_phase);
                        if (st_ff.color_phase == `PHA_PHASE_BLUE) begin
                            nxt_st.pend = PEND_FETCH_CC;
                        end
                    end
                end
                `PHA_SEL_CBM_DATA: begin
                    nxt_st.addr = cbm_idx_inc[7:0];
                    nxt_st.cursor_addr_ext = cbm_idx_inc[9:8];
                end
                default: begin
                    nxt_st.data_oe = 1'b0;
                end
            endcase
        end

        // write effects at the end of the write strobe
        if (wr_rise) begin
            case (st_ff.sel_q)
                `PHA_SEL_ADDR_WR, `PHA_SEL_ADDR_RD,
                `PHA_SEL_CC_ADDR_WR, `PHA_SEL_CC_ADDR_RD: begin
                    nxt_st.addr = st_ff.wdata_q;
                    nxt_st.color_phase = `PHA_PHASE_RED;
                    nxt_st.cursor_addr_ext = cursor_addr_ext_i;
                    nxt_st.pend = PEND_NONE;
                    case (st_ff.sel_q)
                        `PHA_SEL_ADDR_WR: begin
                            nxt_st.mode = MODE_PAL_WR;
                        end
                        `PHA_SEL_ADDR_RD: begin
                            nxt_st.mode = MODE_PAL_RD;
                            nxt_st.pend = PEND_FETCH_PAL;
                        end
                        `PHA_SEL_CC_ADDR_WR: begin
                            nxt_st.mode = MODE_CC_WR;
                        end
                        default: begin
                            nxt_st.mode = MODE_CC_RD;
                            nxt_st.pend = PEND_FETCH_CC;
                        end
                    endcase
                end
                `PHA_SEL_PAL_DATA: begin
                    if (st_ff.mode == MODE_PAL_WR) begin
                        nxt_st.hold[st_ff.color_phase] = wcolor;
                        nxt_st.color_phase =
                            phase_next(st_ff.color_phase);
                        if (st_ff.color_phase == `PHA_PHASE_BLUE) begin
                            nxt_st.pend = PEND_STORE_PAL;
                        end
                    end
                end
                `PHA_SEL_CC_DATA: begin
                    if (st_ff.mode == MODE_CC_WR) begin
                        nxt_st.hold[st_ff.color_phase] = wcolor;
                        nxt_st.color_phase =
                            phase_next(st_ff.color_phase);
                        if (st_ff.color_phase == `PHA_PHASE_BLUE) begin
                            nxt_st.pend = PEND_STORE_CC;
                        end
                    end
                end
                `PHA_SEL_PIX_MASK: begin
                    nxt_st.pix_mask = st_ff.wdata_q;
                end
                `PHA_SEL_CTRL_A: begin
                    nxt_st.ctrl_a = st_ff.wdata_q;
                end
                `PHA_SEL_CTRL_B: begin
                    nxt_st.ctrl_b = st_ff.wdata_q;
                end
                `PHA_SEL_CTRL_C: begin
                    nxt_st.ctrl_c = st_ff.wdata_q;
                end
                `PHA_SEL_CBM_DATA: begin
                    cbm_we = 1'b1;
                    nxt_st.addr = cbm_idx_inc[7:0];
                    nxt_st.cursor_addr_ext = cbm_idx_inc[9:8];
                end
                `PHA_SEL_CUR_X_LO: begin
                    nxt_st.cur_pos.horiz = st_ff.wdata_q;
                end
                `PHA_SEL_CUR_X_HI: begin
                    nxt_st.cur_pos.horiz_hi = st_ff.wdata_q;
                end
                `PHA_SEL_CUR_Y_LO: begin
                    nxt_st.cur_pos.vert = st_ff.wdata_q;
                end
                `PHA_SEL_CUR_Y_HI: begin
                    nxt_st.cur_pos.vert_hi = st_ff.wdata_q;
                end
                default: begin
                    cbm_we = 1'b0;
                end
            endcase
        end

        // memory transfers, only while both strobes are idle
        if (do_op) begin
            nxt_st.pend = PEND_NONE;
            nxt_st.addr = st_ff.addr + 8'h01;
            case (st_ff.pend)
                PEND_STORE_PAL: begin
                    pal_we = 1'b1;
                end
                PEND_FETCH_PAL: begin
                    nxt_st.hold = {pal_mem[st_ff.addr][7:0],
                                   pal_mem[st_ff.addr][15:8],
                                   pal_mem[st_ff.addr][23:16]};
                end
                PEND_STORE_CC: begin
                    cc_we = 1'b1;
                end
                PEND_FETCH_CC: begin
                    nxt_st.hold = {cc_mem[st_ff.addr[1:0]][7:0],
                                   cc_mem[st_ff.addr[1:0]][15:8],
                                   cc_mem[st_ff.addr[1:0]][23:16]};
                end
                default: begin
                    nxt_st.addr = st_ff.addr;
                end
            endcase
        end

        // pixel lookup, held while a transfer uses the memory
        if (!do_op) begin
            nxt_st.color_out = pal_mem[pix_addr];
        end else begin
            nxt_st.color_out = st_ff.color_out;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
            st_ff.mode <= MODE_IDLE;
            st_ff.pend <= PEND_NONE;
            st_ff.wr_n_q <= 1'b1;
            st_ff.rd_n_q <= 1'b1;
            st_ff.pix_mask <= `PHA_MASK_RST;
            st_ff.ctrl_a <= `PHA_CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // memory writes, from the holding word or the latched byte
    always_ff @(posedge mclk_i) begin
        if (pal_we) begin
            pal_mem[st_ff.addr] <= hold_word;
        end
        if (cc_we) begin
            cc_mem[st_ff.addr[1:0]] <= hold_word;
        end
        if (cbm_we) begin
            cbm_mem[cbm_idx] <= cbm_wdata;
        end
    end

    assign host_data_bus_o = st_ff.rdata;
    assign host_data_bus_oe_o = st_ff.data_oe;
    assign color_out_o = st_ff.color_out;
    assign pixel_and_mask_o = st_ff.pix_mask;
    assign control_reg_a_o = st_ff.ctrl_a;
    assign control_reg_b_o = st_ff.ctrl_b;
    assign control_reg_c_o = st_ff.ctrl_c;
    assign cursor_pos_o = st_ff.cur_pos;

endmodule : pha_palette_port

// ==== sim/pha_host_model.sv ====
// host processor model driving the strobed register port
`timescale 1ns/1ps
module pha_host_model
    import pha_pkg::*;
(
    input wire logic mclk_i,
    input wire logic [7:0] host_data_bus_o,
    input wire logic host_data_bus_oe_o,
    output pha_host_t host_o
);
    int extra = 0;

    initial begin
        host_o = '{1'b1, 1'b1, 4'h0, 8'h00};
    end

    // both strobes high over idle edges between accesses
    task automatic gap;
        repeat (3) @(posedge mclk_i);
    endtask : gap

    // low write strobe, byte held until release
    task automatic wr_cycle(logic [3:0] sel, logic [7:0] d);
        @(posedge mclk_i);
        host_o <= '{1'b1, 1'b0, sel, d};
        repeat (2 + extra) @(posedge mclk_i);
        host_o <= '{1'b1, 1'b1, ~sel, ~d};
        gap();
    endtask : wr_cycle

    // low read strobe, byte taken at the releasing edge
    task automatic rd_cycle(logic [3:0] sel, output logic [7:0] d,
        output logic oe);
        @(posedge mclk_i);
        host_o <= '{1'b0, 1'b1, sel, ~host_o.host_data_bus};
        repeat (3 + extra) @(posedge mclk_i);
        d = host_data_bus_o;
        oe = host_data_bus_oe_o;
        host_o <= '{1'b1, 1'b1, ~sel, ~host_o.host_data_bus};
        gap();
    endtask : rd_cycle
endmodule : pha_host_model

// ==== sim/pha_palette_port_chk.sv ====
// assertions on the palette host port pins
`timescale 1ns/1ps
module pha_palette_port_chk
    import pha_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire pha_host_t host_i,
    input wire logic [1:0] cursor_addr_ext_i,
    input wire logic large_cursor_i,
    input wire logic [7:0] pixel_index_i,
    input wire logic [7:0] host_data_bus_o,
    input wire logic host_data_bus_oe_o,
    input wire logic [23:0] color_out_o,
    input wire logic [7:0] pixel_and_mask_o,
    input wire logic [7:0] control_reg_a_o,
    input wire logic [7:0] control_reg_b_o,
    input wire logic [7:0] control_reg_c_o,
    input wire pha_cursor_pos_t cursor_pos_o
);
    logic wr_n_ff;
    logic [3:0] sel_ff;
    logic wr_done;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_n_ff <= 1'b1;
            sel_ff <= 4'h0;
        end else begin
            wr_n_ff <= host_i.wr_n;
            sel_ff <= host_i.reg_select;
        end
    end
    assign wr_done = host_i.wr_n && !wr_n_ff;

    property p_oe_rise;
        $fell(host_i.rd_n) |=> host_data_bus_oe_o;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("oe late");
    property p_oe_drop;
        $rose(host_i.rd_n) |=> !host_data_bus_oe_o;
    endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("oe stuck");
    property p_oe_cause;
        host_data_bus_oe_o |-> !$past(host_i.rd_n);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("stray oe");
    property p_data_stands;
        host_data_bus_oe_o && $past(host_data_bus_oe_o) |->
            $stable(host_data_bus_o);
    endproperty
    a_data_stands: assert property (p_data_stands) else $error("data moved");
    property p_ctrl_cause;
        $changed(control_reg_a_o) |-> $past(wr_done && sel_ff == 4'h6);
    endproperty
    a_ctrl_cause: assert property (p_ctrl_cause) else $error("ctrl moved");
    property p_cpos_write;
        wr_done && sel_ff == 4'hc |=>
            cursor_pos_o.horiz == $past(host_i.host_data_bus, 2);
    endproperty
    a_cpos_write: assert property (p_cpos_write) else $error("x low");
    property p_ctrl_read;
        $fell(host_i.rd_n) && host_i.reg_select == 4'h6 |=>
            host_data_bus_o == control_reg_a_o;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read");
    property p_cpos_read;
        $fell(host_i.rd_n) && host_i.reg_select == 4'hf |=>
            host_data_bus_o == cursor_pos_o.vert_hi;
    endproperty
    a_cpos_read: assert property (p_cpos_read) else $error("y high");
    property p_status;
        $fell(host_i.rd_n) && host_i.reg_select == 4'ha |=>
            host_data_bus_o[7:3] == 5'h00 && host_data_bus_o[1:0] != 2'h3;
    endproperty
    a_status: assert property (p_status) else $error("status");
endmodule : pha_palette_port_chk

bind pha_palette_port pha_palette_port_chk u_chk (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .host_i(host_i),
    .cursor_addr_ext_i(cursor_addr_ext_i), .large_cursor_i(large_cursor_i),
    .pixel_index_i(pixel_index_i), .host_data_bus_o(host_data_bus_o),
    .host_data_bus_oe_o(host_data_bus_oe_o), .color_out_o(color_out_o),
    .pixel_and_mask_o(pixel_and_mask_o), .control_reg_a_o(control_reg_a_o),
    .control_reg_b_o(control_reg_b_o), .control_reg_c_o(control_reg_c_o),
    .cursor_pos_o(cursor_pos_o));

// ==== sim/testbench.sv ====
// self-checking bench for the palette host access port
`timescale 1ns/1ps
module testbench;
    import pha_pkg::*;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    pha_host_t host_i;
    logic [1:0] cursor_addr_ext_i = 2'h0;
    logic large_cursor_i = 1'b0;
    logic [7:0] pixel_index_i = 8'h00;
    logic [7:0] host_data_bus_o;
    logic host_data_bus_oe_o;
    logic [23:0] color_out_o;
    logic [7:0] mask_o, ctl_a_o, ctl_b_o, ctl_c_o;
    pha_cursor_pos_t cursor_pos_o;
    int n_mismatch = 0;
    int n_tests = 0;
    integer seed = 32'he548;
    logic eight = 1'b0;
    logic [23:0] pal [256];
    logic [23:0] ccol [4];
    logic [7:0] v [16];
    logic [3:0] sels [8] = '{4'h2, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf, 4'h6};
    logic [23:0] old;
    logic [7:0] a;

    pha_palette_port DUT (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .host_i(host_i), .cursor_addr_ext_i(cursor_addr_ext_i),
        .large_cursor_i(large_cursor_i), .pixel_index_i(pixel_index_i),
        .host_data_bus_o(host_data_bus_o),
        .host_data_bus_oe_o(host_data_bus_oe_o), .color_out_o(color_out_o),
        .pixel_and_mask_o(mask_o), .control_reg_a_o(ctl_a_o),
        .control_reg_b_o(ctl_b_o), .control_reg_c_o(ctl_c_o),
        .cursor_pos_o(cursor_pos_o));
    pha_host_model host (.mclk_i(mclk_i), .host_data_bus_o(host_data_bus_o),
        .host_data_bus_oe_o(host_data_bus_oe_o), .host_o(host_i));

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    // expected colour byte for a phase
    function automatic logic [7:0] col(logic [23:0] c, int p);
        logic [7:0] b;
        b = c[23 - 8 * p -: 8];
        return eight ? b : (b & 8'h3f);
    endfunction : col

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd_chk(string what, logic [3:0] sel, logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        host.rd_cycle(sel, d, oe);
        check("oe", 32'(oe), 32'h1);
        check(what, 32'(d), 32'(exp));
    endtask : rd_chk

    // address load then whole triples
    task automatic seq_wr(logic cc, logic [7:0] adr, int n);
        logic [23:0] c;
        logic [7:0] x;
        host.wr_cycle(cc ? 4'h4 : 4'h0, adr);
        for (int i = 0; i < n; i++) begin
            x = adr + 8'(i);
            c = 24'($random(seed));
            if (cc) ccol[x[1:0]] = c;
            else pal[x] = c;
            for (int p = 0; p < 3; p++) begin
                host.wr_cycle(cc ? 4'h5 : 4'h1, c[23 - 8 * p -: 8]);
            end
        end
    endtask : seq_wr

    task automatic seq_rd(logic cc, logic [7:0] adr, int n);
        logic [7:0] x;
        host.wr_cycle(cc ? 4'h7 : 4'h3, adr);
        for (int i = 0; i < n; i++) begin
            x = adr + 8'(i);
            for (int p = 0; p < 3; p++) begin
                rd_chk("colour", cc ? 4'h5 : 4'h1,
                    col(cc ? ccol[x[1:0]] : pal[x], p));
            end
        end
    endtask : seq_rd

    initial begin
        repeat (10) @(posedge mclk_i);
        resetn_i <= 1'b1;
        check("mask", 32'(mask_o), 32'hff);
        check("cursor", cursor_pos_o, 32'h0);
        host.wr_cycle(4'h1, 8'h55);
        rd_chk("no mode", 4'h1, 8'h00);
        rd_chk("status", 4'ha, 8'h00);
        foreach (sels[i]) begin
            v[sels[i]] = 8'($random(seed));
            host.wr_cycle(sels[i], v[sels[i]]);
            rd_chk("register", sels[i], v[sels[i]]);
        end
        check("pos", cursor_pos_o, {v[12], v[13], v[14], v[15]});
        check("ctl b", 32'(ctl_b_o), 32'(v[8]));
        check("ctl a", 32'(ctl_a_o), 32'(v[6]));
        check("ctl c", 32'(ctl_c_o), 32'(v[9]));
        check("mask", 32'(mask_o), 32'(v[2]));
        host.wr_cycle(4'ha, 8'hff);
        rd_chk("status", 4'ha, 8'h00);
        host.wr_cycle(4'h2, 8'hff);
        host.wr_cycle(4'h6, 8'h02);
        eight = 1'b1;
        seq_wr(1'b0, 8'hfe, 3);
        rd_chk("addr", 4'h0, 8'h01);
        rd_chk("addr", 4'h3, 8'h01);
        seq_rd(1'b0, 8'hfe, 3);
        seq_wr(1'b0, 8'h10, 2);
        host.wr_cycle(4'h3, 8'h10);
        rd_chk("red", 4'h1, pal[16][23:16]);
        rd_chk("addr", 4'h0, 8'h11);
        rd_chk("green", 4'h1, pal[16][15:8]);
        rd_chk("status", 4'ha, 8'h02);
        rd_chk("blue", 4'h1, pal[16][7:0]);
        rd_chk("next red", 4'h1, pal[17][23:16]);
        host.wr_cycle(4'h0, 8'h30);
        host.wr_cycle(4'h1, 8'h12);
        rd_chk("status", 4'ha, 8'h01);
        host.wr_cycle(4'h0, 8'h30);
        rd_chk("status", 4'ha, 8'h00);
        pixel_index_i <= 8'h10;
        repeat (3) @(posedge mclk_i);
        check("pixel", 32'(color_out_o), 32'(pal[16]));
        old = pal[16];
        seq_wr(1'b0, 8'h10, 1);
        check("hold", 32'(color_out_o), 32'(old));
        repeat (2) @(posedge mclk_i);
        check("pixel", 32'(color_out_o), 32'(pal[16]));
        host.wr_cycle(4'h6, 8'h00);
        eight = 1'b0;
        seq_wr(1'b0, 8'h40, 1);
        seq_rd(1'b0, 8'h40, 1);
        host.wr_cycle(4'h6, 8'h02);
        eight = 1'b1;
        seq_wr(1'b1, 8'hfd, 4);
        seq_rd(1'b1, 8'h02, 4);
        host.wr_cycle(4'h0, 8'h7f);
        host.wr_cycle(4'hb, 8'ha1);
        host.wr_cycle(4'hb, 8'h5e);
        host.wr_cycle(4'h0, 8'h7f);
        rd_chk("plane 0", 4'hb, 8'ha1);
        rd_chk("plane 1", 4'hb, 8'h5e);
        large_cursor_i <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            for (int k = 0; k < 4; k++) begin
                cursor_addr_ext_i <= 2'(k);
                host.wr_cycle(4'h0, 8'hff);
                if (j == 0) host.wr_cycle(4'hb, 8'hc3 ^ 8'(k));
                else rd_chk("large", 4'hb, 8'hc3 ^ 8'(k));
            end
        end
        large_cursor_i <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            host.extra = {$random(seed)} % 3;
            a = 8'($random(seed));
            pixel_index_i <= a;
            seq_wr(1'b0, a, 2);
            seq_rd(1'b0, a, 2);
            check("pixel", 32'(color_out_o), 32'(pal[a]));
        end
        test_done();
    end

    initial begin
        repeat (100000) @(posedge mclk_i);
        n_mismatch++;
        test_done();
    end
endmodule : testbench
